// file: src/rtcao_core.sv
// Notes on behaviour
// [RULE1] alarm polarity sets pin level; idle inverted
// [RULE2] alarm flag set by hardware, software clears
// [RULE3] match select picks trigger fields
// [RULE4] alarm hour format mirrors timekeeping bit
// [RULE5] supply loss captures stamp, sets battery bit
// [RULE6] supply return captures second stamp
// [RULE7] clearing battery bit clears both stamps
// [RULE8] host uses stamps only with oscillator running
// [RULE9] unlock: 0x55 then 0xAA, separate transactions
// [RULE10] id readable always, writes need unlock
// [RULE11] stop after id write relocks area
// [RULE12] trim sign bit subtracts; magnitude doubled
// [RULE13] trim 00h or 80h means no adjustment
// [RULE14] control bit 6 enables clock, 2:0 rate
// [RULE15] rate codes give 32768, 8, 4, 1 cycles; code gives 2 for rate 11 (toggles each tick)
// [RULE16] rate 11 ignores calibration
// [RULE17] 1 Hz: minute period adjusted by trim
// [RULE18] rates 01/10 positive: delayed once per minute
// [RULE19] rate high: every period 2*(256 +/- 2*trim)
// [RULE20] pin: software level, alarm, divided clock
// [RULE21] on battery only alarm output operates
// [RULE22] no register access when supply below trip; code blocks access only when supply is also below battery
// [RULE23] control bits 5:4 enable alarms
// [RULE24] weekday bit 4 is battery status bit
// [RULE25] alarms compared on each seconds update
// [RULE26] bad unlock step restarts, stays locked
`timescale 1ns/1ps
`default_nettype none
module rtcao_core
   import rtcao_pkg::*;
(
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    resetn,
   // timekeeping interface
   input  wire logic                    osc_tick,
   input  wire logic                    second_tick,
   input  wire logic                    minute_tick,
   input  wire rtcao_pkg::rtcao_time_s  time_now,
   // alarm settings and flag clears
   input  wire rtcao_pkg::rtcao_alarm_s alarm0_cfg,
   input  wire rtcao_pkg::rtcao_alarm_s alarm1_cfg,
   input  wire logic [1:0]              alarm_flag_clr,
   output logic [1:0]                   alarm_flag,
   output logic [7:0]                   alarm_hour_fmt,
   // supply state (pins, asynchronous)
   input  wire logic                    supply_fail_pin,
   input  wire logic                    battery_above_pin,
   input  wire logic                    battery_status_clr,
   output logic                         battery_status,
   output logic                         access_allow,
   // register port from the serial engine
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    bus_stop,
   output logic [7:0]                   reg_rdata,
   output logic                         id_write_allow,
   output logic                         id_write_start,
   // multi-function pin (open drain)
   output logic                         multi_function_pin_o,
   output logic                         multi_function_pin_oe
);
   import rtcao_pkg::*;

   logic [7:0]    output_control_r;
   logic [7:0]    trim_adjust_r;
   logic [31:0]   loss_stamp_r;
   logic [31:0]   return_stamp_r;
   logic [1:0]    fail_sync_r;
   logic [1:0]    bat_sync_r;
   logic          on_battery_r;
   logic          acc_r;
   rtcao_unlock_e unl_r;
   logic          key_seen_r;
   logic          id_written_r;
   logic [1:0]    alarm_hit;
   logic [31:0]   stamp_now;

   // alarm match according to select field
   function automatic logic alarm_match(input rtcao_alarm_s a, input rtcao_time_s t);
      logic m;
      m = 1'b0;
      case (a.match_sel) // RULE3
         MATCH_SEC:  m = (a.sec[6:0] == t.sec[6:0]);
         MATCH_MIN:  m = (a.min[6:0] == t.min[6:0]);
         MATCH_HOUR: m = (a.hour[5:0] == t.hour[5:0]); // am/pm bit included
         MATCH_WDAY: m = (a.wday == t.wday) && (t.hour[5:0] == 6'h00 || t.hour == 8'h52)
                         && (t.min == 8'h00) && (t.sec[6:0] == 7'h00);
         MATCH_DATE: m = (a.date == t.date);
         MATCH_ALL:  m = (a.sec[6:0] == t.sec[6:0]) && (a.min == t.min)
                         && (a.hour[5:0] == t.hour[5:0]) && (a.wday == t.wday)
                         && (a.date == t.date) && (a.month == t.month);
         default:    m = 1'b0;
      endcase
      return m;
   endfunction

   // pin inputs synchronised
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fail_sync_r <= 2'b00;
         bat_sync_r  <= 2'b00;
      end else begin
         fail_sync_r <= {fail_sync_r[0], supply_fail_pin};
         bat_sync_r  <= {bat_sync_r[0], battery_above_pin};
      end
   end

   // access allowed unless below trip and below battery
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) acc_r <= 1'b1;
      else         acc_r <= !(fail_sync_r[1] && bat_sync_r[1]); // RULE22
   end
   assign access_allow = acc_r;

   // alarm evaluation on the seconds update
   assign alarm_hit[0] = second_tick && output_control_r[CTL_ALM0_EN]
                         && alarm_match(alarm0_cfg, time_now); // RULE25 RULE23
   assign alarm_hit[1] = second_tick && output_control_r[CTL_ALM1_EN]
                         && alarm_match(alarm1_cfg, time_now); // RULE25 RULE23

   // sticky alarm flags, set beats clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) alarm_flag <= 2'b00;
      else         alarm_flag <= alarm_hit | (alarm_flag & ~alarm_flag_clr); // RULE2
   end

   // hour format mirror into alarm hour registers
   assign alarm_hour_fmt = {time_now.hour[HOUR_FMT_BIT], 7'h00}; // RULE4

   // supply state and time stamps
   // stamp bytes: minutes, hours, date, weekday with month
   assign stamp_now = {time_now.min, time_now.hour, time_now.date,
                       time_now.wday, time_now.month[4:0]};
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         on_battery_r   <= 1'b0;
         battery_status <= 1'b0;
         loss_stamp_r   <= 32'h0;
         return_stamp_r <= 32'h0;
      end else begin
         on_battery_r <= !acc_r;
         if (!acc_r && !on_battery_r) begin
            loss_stamp_r   <= stamp_now; // RULE5
            battery_status <= 1'b1; // RULE24
         end else if (battery_status_clr) begin
            battery_status <= 1'b0;
            loss_stamp_r   <= 32'h0; // RULE7
            return_stamp_r <= 32'h0; // RULE7
         end
         if (acc_r && on_battery_r) begin
            return_stamp_r <= stamp_now; // RULE6
         end
      end
   end

   // control and trim registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         output_control_r <= CTL_RESET;
         trim_adjust_r    <= TRIM_RESET;
      end else if (reg_wr && acc_r) begin // RULE22
         if (reg_addr == OFS_OUTPUT_CONTROL) begin
            output_control_r <= reg_wdata; // RULE14
         end else if (reg_addr == OFS_TRIM_ADJUST) begin
            trim_adjust_r <= reg_wdata; // RULE12
         end
      end
   end

   // unique id unlock sequence, stepped at each stop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unl_r        <= UNL_IDLE;
         key_seen_r   <= 1'b0;
         id_written_r <= 1'b0;
      end else begin
         if (reg_wr && acc_r && reg_addr == OFS_ID_UNLOCK_KEY) begin
            if (unl_r == UNL_IDLE && reg_wdata == KEY_FIRST && !key_seen_r)
               key_seen_r <= 1'b1;
            else if (unl_r == UNL_HALF && reg_wdata == KEY_SECOND && !key_seen_r)
               key_seen_r <= 1'b1;
            else begin
               unl_r      <= UNL_IDLE; // RULE26
               key_seen_r <= 1'b0;
            end
         end
         if (reg_wr && acc_r && unl_r == UNL_OPEN
             && reg_addr >= OFS_ID_FIRST && reg_addr <= OFS_ID_LAST)
            id_written_r <= 1'b1;
         if (bus_stop) begin
            key_seen_r <= 1'b0;
            case (unl_r) // RULE9
               UNL_IDLE: unl_r <= key_seen_r ? UNL_HALF : UNL_IDLE;
               UNL_HALF: unl_r <= key_seen_r ? UNL_OPEN : UNL_IDLE;
               UNL_OPEN: if (id_written_r) begin
                  unl_r        <= UNL_IDLE; // RULE11
                  id_written_r <= 1'b0;
               end
               default:  unl_r <= UNL_IDLE;
            endcase
         end
      end
   end
   assign id_write_allow = (unl_r == UNL_OPEN); // RULE10
   assign id_write_start = bus_stop && id_written_r; // RULE11

   // register readback
   always_comb begin
      reg_rdata = 8'h00;
      if (!acc_r) reg_rdata = 8'h00; // RULE22
      else if (reg_addr == OFS_OUTPUT_CONTROL) reg_rdata = output_control_r;
      else if (reg_addr == OFS_TRIM_ADJUST) reg_rdata = trim_adjust_r;
      else if (reg_addr >= OFS_LOSS_STAMP && reg_addr < OFS_RETURN_STAMP)
         reg_rdata = loss_stamp_r[8'd31 - {reg_addr[1:0], 3'h0} -: 8];
      else if (reg_addr >= OFS_RETURN_STAMP && reg_addr <= 8'h1F)
         reg_rdata = return_stamp_r[8'd31 - {reg_addr[1:0], 3'h0} -: 8];
   end

   // divided clock generator on oscillator ticks
   logic [16:0] div_cnt_r;
   logic        div_out_r;
   logic [16:0] half_per;
   logic [8:0]  trim_twice;
   logic        trim_on;
   logic        cal_pend_r;
   logic [8:0]  cal_hold_r; // ticks the waveform is still held back
   assign trim_twice = {1'b0, trim_adjust_r[6:0], 1'b0}; // RULE12
   assign trim_on    = (trim_adjust_r[6:0] != 7'h00); // RULE13

   always_comb begin
      half_per = PER_1HZ >> 1;
      if (output_control_r[CTL_RATE_HIGH]) begin
         if (!trim_on) half_per = PER_CAL; // RULE19
         else if (trim_adjust_r[7]) half_per = PER_CAL - {8'h00, trim_twice};
         else half_per = PER_CAL + {8'h00, trim_twice};
      end else begin
         case (output_control_r[1:0]) // RULE15
            2'b00:   half_per = PER_1HZ >> 1;
            2'b01:   half_per = PER_4K >> 1;
            2'b10:   half_per = PER_8K >> 1;
            default: half_per = 17'h00001;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_r  <= 17'h0;
         div_out_r  <= 1'b0;
         cal_pend_r <= 1'b0;
         cal_hold_r <= 9'h000;
      end else begin
         if (minute_tick && trim_on && !output_control_r[CTL_RATE_HIGH]
             && output_control_r[1:0] != 2'b11) // RULE16
            cal_pend_r <= 1'b1;
         if (osc_tick) begin
            if (cal_hold_r != 9'h000) begin
               cal_hold_r <= cal_hold_r - 9'h001; // RULE18
            end else if (output_control_r[1:0] == 2'b11 && !output_control_r[CTL_RATE_HIGH]) begin
               div_out_r <= !div_out_r; // RULE16
               div_cnt_r <= 17'h0;
            end else if (div_cnt_r + 17'h1 >= half_per) begin
               div_out_r <= !div_out_r;
               div_cnt_r <= 17'h0;
               if (cal_pend_r && !div_out_r) begin
                  cal_pend_r <= 1'b0;
                  if (trim_adjust_r[7]) // RULE17
                     div_cnt_r <= {8'h00, trim_twice};
                  else
                     cal_hold_r <= trim_twice; // RULE17 RULE18
               end
            end else begin
               div_cnt_r <= div_cnt_r + 17'h1;
            end
         end
      end
   end

   // pin mux; open drain drives low only
   logic alarm_any;
   logic pin_level;
   assign alarm_any = |alarm_flag;
   always_comb begin
      pin_level = output_control_r[CTL_OUT_LEVEL]; // RULE20
      if (on_battery_r) // RULE21
         pin_level = alarm_any ? alarm0_cfg.polarity : !alarm0_cfg.polarity;
      else if (output_control_r[CTL_CLK_EN])
         pin_level = div_out_r; // RULE14
      else if (output_control_r[CTL_ALM0_EN] || output_control_r[CTL_ALM1_EN])
         pin_level = alarm_any ? alarm0_cfg.polarity : !alarm0_cfg.polarity; // RULE1
   end
   assign multi_function_pin_o  = 1'b0;
   assign multi_function_pin_oe = !pin_level;
endmodule
`default_nettype wire

// file: src/rtcao_pkg.sv
package rtcao_pkg;
   // register offsets (byte addresses of the internal map)
   localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h07;
   localparam logic [7:0] OFS_TRIM_ADJUST    = 8'h08;
   localparam logic [7:0] OFS_ID_UNLOCK_KEY  = 8'h09;
   localparam logic [7:0] OFS_LOSS_STAMP     = 8'h18;
   localparam logic [7:0] OFS_RETURN_STAMP   = 8'h1C;
   localparam logic [7:0] OFS_ID_FIRST       = 8'hF0;
   localparam logic [7:0] OFS_ID_LAST        = 8'hF7;
   // unlock keys
   localparam logic [7:0] KEY_FIRST          = 8'h55;
   localparam logic [7:0] KEY_SECOND         = 8'hAA;
   // control register fields
   localparam int CTL_OUT_LEVEL  = 7;
   localparam int CTL_CLK_EN     = 6;
   localparam int CTL_ALM1_EN    = 5;
   localparam int CTL_ALM0_EN    = 4;
   localparam int CTL_RATE_HIGH  = 2;
   localparam logic [7:0] CTL_RESET  = 8'h80;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   // alarm match select codes
   localparam logic [2:0] MATCH_SEC   = 3'h0;
   localparam logic [2:0] MATCH_MIN   = 3'h1;
   localparam logic [2:0] MATCH_HOUR  = 3'h2;
   localparam logic [2:0] MATCH_WDAY  = 3'h3;
   localparam logic [2:0] MATCH_DATE  = 3'h4;
   localparam logic [2:0] MATCH_ALL   = 3'h7;
   // output periods in input clock cycles
   localparam logic [16:0] PER_1HZ    = 17'h08000;
   localparam logic [16:0] PER_4K     = 17'h00008;
   localparam logic [16:0] PER_8K     = 17'h00004;
   localparam logic [16:0] PER_CAL    = 17'h00100; // half period, 256
   // hour register 12/24 bit
   localparam int HOUR_FMT_BIT = 6;

   // current time counters (bcd)
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [2:0] wday;
      logic [7:0] date;
      logic [7:0] month;
   } rtcao_time_s;

   // one alarm's settings
   typedef struct packed {
      logic       polarity;
      logic [2:0] match_sel;
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [2:0] wday;
      logic [7:0] date;
      logic [7:0] month;
   } rtcao_alarm_s;

   typedef enum logic [1:0] {
      UNL_IDLE  = 2'b00,
      UNL_HALF  = 2'b01,
      UNL_OPEN  = 2'b10
   } rtcao_unlock_e;
endpackage

// file: tb/rtcao_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rtcao_core_monitor
   import rtcao_pkg::*;
(
   // clock and reset
   input wire logic                   sys_clk,
   input wire logic                   resetn,
   // alarm and supply side
   input wire rtcao_pkg::rtcao_time_s time_now,
   input wire logic [1:0]             alarm_flag_clr,
   input wire logic [1:0]             alarm_flag,
   input wire logic [7:0]             alarm_hour_fmt,
   input wire logic                   battery_status_clr,
   input wire logic                   battery_status,
   input wire logic                   access_allow,
   // register port
   input wire logic                   reg_wr,
   input wire logic [7:0]             reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   bus_stop,
   input wire logic [7:0]             reg_rdata,
   input wire logic                   id_write_allow,
   input wire logic                   id_write_start
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // format bit copies the hour register
   property p_fmt;
      alarm_hour_fmt[7] == time_now.hour[HOUR_FMT_BIT];
   endproperty
   a_fmt: assert property (p_fmt) else $error("hour format copy wrong");
   // flags hold until cleared
   property p_flag;
      alarm_flag[0] && !alarm_flag_clr[0] |=> alarm_flag[0];
   endproperty
   a_flag: assert property (p_flag) else $error("alarm flag lost");
   property p_bat;
      battery_status && !battery_status_clr |=> battery_status;
   endproperty
   a_bat: assert property (p_bat) else $error("battery bit lost");
   // unlock completes only after a stop
   property p_unlock;
      $rose(id_write_allow) |-> $past(bus_stop);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock without stop");
   property p_relock;
      id_write_start |=> !id_write_allow;
   endproperty
   a_relock: assert property (p_relock) else $error("area not relocked");
   property p_locked;
      id_write_start |-> id_write_allow;
   endproperty
   a_locked: assert property (p_locked) else $error("write while locked");
   // clearing battery bit empties stamps
   property p_stamp;
      $fell(battery_status) && access_allow && reg_addr == OFS_LOSS_STAMP |-> reg_rdata == 8'h00;
   endproperty
   a_stamp: assert property (p_stamp) else $error("stamp not cleared");
   property p_refuse;
      !access_allow |-> reg_rdata == 8'h00;
   endproperty
   a_refuse: assert property (p_refuse) else $error("read while refused");
   property p_trim;
      reg_wr && access_allow && reg_addr == OFS_TRIM_ADJUST |=>
         reg_addr != OFS_TRIM_ADJUST || !access_allow || reg_rdata == $past(reg_wdata);
   endproperty
   a_trim: assert property (p_trim) else $error("trim not stored");
   // main scenarios
   c_unlock: cover property ($rose(id_write_allow));
   c_bat: cover property ($rose(battery_status));
   c_flag: cover property ($rose(alarm_flag[0]));
endmodule
bind rtcao_core rtcao_core_monitor rtcao_core_monitor_i (
   .sys_clk, .resetn, .time_now, .alarm_flag_clr, .alarm_flag, .alarm_hour_fmt,
   .battery_status_clr, .battery_status, .access_allow, .reg_wr, .reg_addr,
   .reg_wdata, .bus_stop, .reg_rdata, .id_write_allow, .id_write_start);
`default_nettype wire

// file: tb/rtcao_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcao_host_model
   import rtcao_pkg::*;
(
   // clock
   input wire logic   sys_clk,
   // register port toward the device
   output logic       reg_wr,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic       bus_stop
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      bus_stop = 1'h0;
   end
   // one byte write, then stop closes the transaction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'h0;
      reg_wdata = ~d;
      bus_stop = 1'h1;
      @(posedge sys_clk);
      #1;
      bus_stop = 1'h0;
   endtask
   // address set for a read
   task automatic addr(input logic [7:0] a);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
   endtask
   // two keys in separate transactions
   task automatic unlock();
      wr(OFS_ID_UNLOCK_KEY, KEY_FIRST);
      wr(OFS_ID_UNLOCK_KEY, KEY_SECOND);
   endtask
endmodule
`default_nettype wire

// file: tb/test_rtc_alarm_calib_output.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtc_alarm_calib_output;
   import rtcao_pkg::*;
   typedef struct packed {logic [7:0] ctl; logic [2:0] sel; logic [7:0] sec; logic exp;} rtcao_row_s;
   logic sys_clk = 1'h0, resetn = 1'h0, osc_tick = 1'h0, second_tick = 1'h0;
   logic minute_tick = 1'h0;
   logic supply_fail_pin = 1'h0, battery_above_pin = 1'h0, battery_status_clr = 1'h0;
   logic [1:0] alarm_flag_clr = 2'h0, osc_cnt = 2'h0, alarm_flag;
   logic [7:0] alarm_hour_fmt, reg_addr, reg_wdata, reg_rdata, rises;
   logic reg_wr, bus_stop, battery_status, access_allow, id_write_allow, id_write_start;
   logic multi_function_pin_o, multi_function_pin_oe;
   rtcao_time_s time_now = '{8'h00, 8'h00, 8'h00, 3'h1, 8'h01, 8'h01};
   rtcao_alarm_s alarm0_cfg = '{1'h1, 3'h0, 8'h00, 8'h00, 8'h00, 3'h1, 8'h01, 8'h01};
   int num_errors = 0, compares = 0, starts = 0;
   rtcao_row_s rows[11] = '{'{8'h10, 3'h0, 8'h00, 1'h1}, '{8'h10, 3'h0, 8'h01, 1'h0},
      '{8'h10, 3'h1, 8'h00, 1'h1}, '{8'h10, 3'h2, 8'h00, 1'h1}, '{8'h10, 3'h3, 8'h00, 1'h1},
      '{8'h10, 3'h3, 8'h01, 1'h0}, '{8'h10, 3'h4, 8'h00, 1'h1}, '{8'h10, 3'h7, 8'h00, 1'h1},
      '{8'h10, 3'h7, 8'h01, 1'h0}, '{8'h00, 3'h0, 8'h00, 1'h0},
      '{8'h10, 3'h5, 8'h00, 1'h0}};
   logic [7:0] st_ofs[5] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C};
   logic [7:0] st_exp[5] = '{8'h34, 8'h52, 8'h25, 8'hB1, 8'h35};
   rtcao_core rtcao_core_i (.sys_clk, .resetn, .osc_tick, .second_tick, .minute_tick,
      .time_now, .alarm0_cfg, .alarm1_cfg(alarm0_cfg), .alarm_flag_clr, .alarm_flag,
      .alarm_hour_fmt, .supply_fail_pin, .battery_above_pin, .battery_status_clr,
      .battery_status, .access_allow, .reg_wr, .reg_addr, .reg_wdata, .bus_stop, .reg_rdata,
      .id_write_allow, .id_write_start, .multi_function_pin_o, .multi_function_pin_oe);
   rtcao_host_model rtcao_host_model_i (.sys_clk, .reg_wr, .reg_addr, .reg_wdata, .bus_stop);
   // clock, oscillator running throughout, id write starts
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      osc_cnt <= osc_cnt + 2'h1;
      osc_tick <= (osc_cnt == 2'h3);
      if (id_write_start) starts++;
   end
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      rtcao_host_model_i.addr(a);
      #1;
      chk(what, reg_rdata, exp);
   endtask
   // rising edges of pin drive over 32 oscillator ticks
   task automatic count_rises(output logic [7:0] n);
      logic prev;
      n = 8'h00;
      prev = multi_function_pin_oe;
      repeat (128) begin
         step(1);
         if (multi_function_pin_oe && !prev) n++;
         prev = multi_function_pin_oe;
      end
   endtask
   task automatic close_out();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
   initial begin
      step(16);
      resetn = 1'h1;
      step(1);
      rd_chk("control reset", OFS_OUTPUT_CONTROL, 8'h80);
      rd_chk("trim reset", OFS_TRIM_ADJUST, 8'h00);
      chk("pin out level", {7'h0, multi_function_pin_oe}, 8'h00);
      chk("pin drive", {7'h0, multi_function_pin_o}, 8'h00);
      $display("done reset");
      foreach (rows[i]) begin
         rtcao_host_model_i.wr(OFS_OUTPUT_CONTROL, rows[i].ctl);
         alarm0_cfg.match_sel = rows[i].sel;
         time_now.sec = rows[i].sec;
         alarm_flag_clr = 2'h3;
         step(1);
         alarm_flag_clr = 2'h0;
         second_tick = 1'h1;
         step(1);
         second_tick = 1'h0;
         step(2);
         chk("alarm flag", {7'h0, alarm_flag[0]}, {7'h0, rows[i].exp});
         chk("alarm pin", {7'h0, multi_function_pin_oe}, {7'h0, !rows[i].exp});
      end
      $display("done alarms");
      rtcao_host_model_i.wr(OFS_TRIM_ADJUST, 8'h85);
      rd_chk("trim", OFS_TRIM_ADJUST, 8'h85);
      for (int r = 1; r <= 2; r++) begin
         rtcao_host_model_i.wr(OFS_OUTPUT_CONTROL, 8'h40 | 8'(r));
         step(8);
         count_rises(rises);
         chk("clock rises", rises, 8'h04 << (r - 1));
      end
      // minute update: 80h leaves timing, 04h holds one period back
      for (int t = 0; t < 2; t++) begin
         rtcao_host_model_i.wr(OFS_TRIM_ADJUST, (t == 0) ? 8'h80 : 8'h04);
         rtcao_host_model_i.wr(OFS_OUTPUT_CONTROL, 8'h41);
         step(8);
         minute_tick = 1'h1;
         step(1);
         minute_tick = 1'h0;
         count_rises(rises);
         chk("minute trim", rises, (t == 0) ? 8'h04 : 8'h03);
      end
      $display("done clock");
      rtcao_host_model_i.wr(OFS_ID_FIRST, 8'h12);
      rtcao_host_model_i.wr(OFS_ID_UNLOCK_KEY, KEY_SECOND);
      rtcao_host_model_i.wr(OFS_ID_UNLOCK_KEY, KEY_SECOND);
      chk("bad unlock", {7'h0, id_write_allow}, 8'h00);
      rtcao_host_model_i.unlock();
      step(1);
      chk("unlock", {7'h0, id_write_allow}, 8'h01);
      chk("locked write", 8'(starts), 8'h00);
      rtcao_host_model_i.wr(8'hF1, 8'h34);
      step(1);
      chk("id write", 8'(starts), 8'h01);
      chk("relock", {7'h0, id_write_allow}, 8'h00);
      $display("done unlock");
      time_now = '{8'h00, 8'h34, 8'h52, 3'h5, 8'h25, 8'h11};
      supply_fail_pin = 1'h1;
      battery_above_pin = 1'h1;
      for (int k = 0; k < 20 && battery_status !== 1'h1; k++) step(1);
      chk("battery bit", {7'h0, battery_status}, 8'h01);
      chk("hour format", alarm_hour_fmt, 8'h80);
      chk("access", {7'h0, access_allow}, 8'h00);
      count_rises(rises);
      chk("clock on battery", rises, 8'h00);
      rtcao_host_model_i.wr(OFS_TRIM_ADJUST, 8'h11);
      time_now.min = 8'h35;
      supply_fail_pin = 1'h0;
      for (int k = 0; k < 20 && access_allow !== 1'h1; k++) step(1);
      rd_chk("trim kept", OFS_TRIM_ADJUST, 8'h04);
      for (int i = 0; i < 5; i++) rd_chk("stamp", st_ofs[i], st_exp[i]);
      rtcao_host_model_i.addr(OFS_LOSS_STAMP);
      battery_status_clr = 1'h1;
      step(1);
      battery_status_clr = 1'h0;
      step(1);
      chk("battery clear", {7'h0, battery_status}, 8'h00);
      rd_chk("loss stamp", OFS_LOSS_STAMP, 8'h00);
      rd_chk("return stamp", OFS_RETURN_STAMP, 8'h00);
      $display("done supply");
      close_out();
   end
endmodule
`default_nettype wire
